// file: rtl/dsrp_port.sv
// Slave serial access port that lets an outside master read and write the
// 8-bit registers, over a two-wire bus or a 4-wire / 3-wire SPI.
// Assumes the register file answers reg_rdata combinationally for
// reg_rd_addr on clk_sys, and that all pins arrive asynchronously.

// Overview of operation.
// The block sits between the shared serial pads and the register file. It
// never owns the registers; it only produces a pointer, read strobes and
// write strobes, and takes read data back combinationally.
//
// Pin handling.
// Every pad input passes a two-stage synchroniser before any decision is
// made, and a third stage gives the previous level for edge detection.
// An event on a pad therefore acts three clk_sys edges after it happens.
// The master's clock is never used as a clock here. It is sampled like any
// other pad and its rising and falling edges are found by comparison.
// The trade-off is a minimum pad level time of about three clk_sys cycles.
// Both bus rates and the bench's SPI clock leave a wide margin above that.
// Glitches shorter than one clk_sys period may be missed or seen once;
// the pads are expected to be clean, as the master drives them.
//
// Protocol choice.
// The select pad level alone picks the protocol. While it is high the SPI
// side is held at bit zero and undriven, and the two-wire side may run.
// While it is low the two-wire side is forced idle and its drive dropped.
// The two-wire disable input also forces the two-wire side idle, so a host
// that only speaks SPI cannot be confused by traffic on the clock pad.
//
// Two-wire slave.
// A start with the clock high opens the address byte. Bits are taken at
// each clock rise and the byte is judged at the falling edge that follows
// the eighth bit. A matching address with the busy input low is answered
// by pulling the data pad low until the next falling clock edge. Any other
// address, or a busy device, leaves the pad released and the slave waits
// for the next start. A stop anywhere returns it to idle.
// After a write address the next byte is the sub-address: it loads the
// shared pointer and the stepping flag. Each later byte is written at the
// falling edge that ends its eighth bit, then the pointer may step.
// After a read address the byte at the pointer is loaded when the address
// acknowledge ends and is shifted out one bit per falling clock edge.
// A low acknowledge from the master fetches the next byte; a high one
// ends the read and the slave stays quiet until a stop or a new start.
// A read with no sub-address first simply reuses the last pointer.
// The slave never stretches the clock, so it cannot make a fast master
// wait; this is why read data must come combinationally from the file.
//
// SPI slave.
// Frames open at the synchronised select fall. The first eight rising
// clock edges carry direction, stepping and the six-bit address; the
// pointer loads at the eighth. A write frame then takes a data byte per
// eight rises and strobes it at the last rise of the block.
// A read frame loads the byte at the pointer at the falling edge after
// the eighth rise and starts to drive it; each later falling edge shifts
// it by one bit and every eighth falls loads the next byte.
// The read byte goes out on the dedicated output pad in 4-wire mode and
// on the shared data pad in 3-wire mode, selected by the mode input.
// A block cut short by the select rise is dropped and never written.
//
// Shared pointer.
// Both protocols use one pointer, since only one of them can be active at
// a time. Its top bit is always zero after an SPI command, because the
// SPI address field is one bit narrower than the register address.
// The pointer steps after each whole data byte when stepping is enabled.
//
// Limitations.
// There is no general call, no ten-bit addressing and no clock stretching.
// A master that changes data while the clock is high, other than for a
// start or stop, will be read as a start or stop by this slave.
// The mode and disable inputs are expected to change only between frames;
// a change in mid-frame takes effect at once and may cut the transfer.
// Holding the clock enable low freezes every stage including the pads'
// synchronisers, so edges that come and go during the freeze are lost.
//
// Reset.
// The asynchronous reset clears every output and presets the synchroniser
// stages to the idle pad levels, which are high. This keeps the first
// edges after reset from being taken as a start, a stop or a select fall.
`timescale 1ns/100ps
`default_nettype none
`include "dsrp_defs.svh"

module dsrp_port
    import dsrp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic chip_select_pin,
    input wire logic scl_spc_pin,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic serial_out_line,
    output logic serial_out_oe,
    input wire logic wire_mode_select,
    input wire logic two_wire_disable,
    input wire logic busy,
    output logic [`DSRP_ADDR_W-1:0] reg_rd_addr,
    output logic reg_rd_strobe,
    input wire logic [`DSRP_DATA_W-1:0] reg_rdata,
    output logic reg_wr_strobe,
    output logic [`DSRP_ADDR_W-1:0] reg_wr_addr,
    output logic [`DSRP_DATA_W-1:0] reg_wr_data
);

    dsrp_state_t st;
    dsrp_state_t next_st;

    logic cs_high;
    logic cs_fall;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic i2c_start;
    logic i2c_stop;
    logic i2c_en;

    function automatic logic [`DSRP_ADDR_W-1:0] step_addr(
        input logic [`DSRP_ADDR_W-1:0] a,
        input logic en
    );
        step_addr = en ? a + 7'h01 : a;
    endfunction

    // Edges are taken from the second and third stages only, so the first
    // synchroniser stage never feeds any decision.
    assign cs_high = st.sync.cs[1];
    assign cs_fall = st.sync.cs[2] & ~st.sync.cs[1];
    assign scl_rise = st.sync.scl[1] & ~st.sync.scl[2];
    assign scl_fall = st.sync.scl[2] & ~st.sync.scl[1];
    assign sda_lvl = st.sync.sda[1];
    assign i2c_start = st.sync.scl[1] & st.sync.scl[2] &
                       st.sync.sda[2] & ~st.sync.sda[1];
    assign i2c_stop = st.sync.scl[1] & st.sync.scl[2] &
                      ~st.sync.sda[2] & st.sync.sda[1];
    assign i2c_en = cs_high & ~two_wire_disable;

    always_comb begin
        next_st = st;
        next_st.sync.cs = {st.sync.cs[1:0], chip_select_pin};
        next_st.sync.scl = {st.sync.scl[1:0], scl_spc_pin};
        next_st.sync.sda = {st.sync.sda[1:0], sda_in};
        next_st.wr.strobe = 1'b0;
        next_st.rd_strobe = 1'b0;

        // Two-wire slave. Sampling at the synchronised clock edges leaves
        // ample margin, since even a 400 kHz bus gives over 600 clk_sys
        // cycles per bit.
        if (!i2c_en) begin
            next_st.ist = DSRP_I_IDLE;
            next_st.idrive = 1'b0;
        end else if (i2c_stop) begin
            next_st.ist = DSRP_I_IDLE;
            next_st.idrive = 1'b0;
        end else if (i2c_start) begin
            next_st.ist = DSRP_I_ADDR;
            next_st.icnt = 4'h0;
            next_st.idrive = 1'b0;
        end else begin
            case (st.ist)
                DSRP_I_ADDR, DSRP_I_SUB, DSRP_I_WDATA: begin
                    if (scl_rise) begin
                        next_st.ish = {st.ish[6:0], sda_lvl};
                        next_st.icnt = st.icnt + 4'h1;
                    end else if (scl_fall && st.icnt == `DSRP_I2C_BITS) begin
                        next_st.icnt = 4'h0;
                        next_st.ist = DSRP_I_ACK;
                        next_st.idrive = 1'b1;
                        if (st.ist == DSRP_I_ADDR) begin
                            next_st.irw = st.ish[0];
                            next_st.iret = (st.ish[0] == `DSRP_DIR_READ) ?
                                           DSRP_I_RDATA : DSRP_I_SUB;
                            if (st.ish[7:1] != `DSRP_SLAVE_ADDR ||
                                busy) begin
                                next_st.ist = DSRP_I_IDLE;
                                next_st.idrive = 1'b0;
                            end
                        end else if (st.ist == DSRP_I_SUB) begin
                            next_st.ptr = st.ish[`DSRP_ADDR_W-1:0];
                            next_st.iinc = st.ish[`DSRP_SUB_INC_BIT];
                            next_st.iret = DSRP_I_WDATA;
                        end else begin
                            next_st.wr.strobe = 1'b1;
                            next_st.wr.addr = st.ptr;
                            next_st.wr.data = st.ish;
                            next_st.ptr = step_addr(st.ptr, st.iinc);
                        end
                    end
                end
                DSRP_I_ACK: begin
                    if (scl_fall) begin
                        next_st.idrive = 1'b0;
                        next_st.ist = st.iret;
                        if (st.iret == DSRP_I_RDATA) begin
                            next_st.ish = reg_rdata;
                            next_st.rd_strobe = 1'b1;
                            next_st.idrive = ~reg_rdata[7];
                        end
                    end
                end
                DSRP_I_RDATA: begin
                    if (scl_rise) begin
                        next_st.icnt = st.icnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st.icnt == `DSRP_I2C_BITS) begin
                            next_st.icnt = 4'h0;
                            next_st.idrive = 1'b0;
                            next_st.ist = DSRP_I_MACK;
                            next_st.ptr = step_addr(st.ptr, st.iinc);
                        end else begin
                            next_st.ish = {st.ish[6:0], 1'b0};
                            next_st.idrive = ~st.ish[6];
                        end
                    end
                end
                DSRP_I_MACK: begin
                    // A master no-acknowledge ends the read; the slave then
                    // waits quietly for the stop or a repeated start.
                    if (scl_rise) begin
                        next_st.iret = sda_lvl ? DSRP_I_IDLE : DSRP_I_RDATA;
                    end else if (scl_fall) begin
                        next_st.ist = st.iret;
                        if (st.iret == DSRP_I_RDATA) begin
                            next_st.ish = reg_rdata;
                            next_st.rd_strobe = 1'b1;
                            next_st.idrive = ~reg_rdata[7];
                        end
                    end
                end
                default: begin
                    next_st.idrive = 1'b0;
                end
            endcase
        end

        // SPI slave, active only while select is low.
        if (cs_high || cs_fall) begin
            next_st.sbit = 3'h0;
            next_st.sphase = 1'b0;
            next_st.sdrive = 1'b0;
        end else begin
            if (scl_rise) begin
                next_st.ssh = {st.ssh[6:0], sda_lvl};
                next_st.sbit = st.sbit + 3'h1;
                if (st.sbit == `DSRP_BYTE_LAST) begin
                    next_st.sphase = 1'b1;
                    if (!st.sphase) begin
                        next_st.srw = st.ssh[6];
                        next_st.sms = st.ssh[5];
                        next_st.ptr = {1'b0, st.ssh[4:0], sda_lvl};
                    end else if (st.srw == `DSRP_DIR_WRITE) begin
                        next_st.wr.strobe = 1'b1;
                        next_st.wr.addr = st.ptr;
                        next_st.wr.data = {st.ssh[6:0], sda_lvl};
                        next_st.ptr = step_addr(st.ptr, st.sms);
                    end else begin
                        next_st.ptr = step_addr(st.ptr, st.sms);
                    end
                end
            end else if (scl_fall && st.sphase &&
                         st.srw == `DSRP_DIR_READ) begin
                if (st.sbit == 3'h0) begin
                    next_st.sosh = reg_rdata;
                    next_st.rd_strobe = 1'b1;
                    next_st.sdrive = 1'b1;
                end else begin
                    next_st.sosh = {st.sosh[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.sync.cs <= 3'h7;
            st.sync.scl <= 3'h7;
            st.sync.sda <= 3'h7;
            st.ist <= DSRP_I_IDLE;
            st.iret <= DSRP_I_IDLE;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Mode select and two-wire disable are held by the register file, whose
    // reset leaves them at 4-wire SPI with the two-wire slave enabled.
    always_comb begin
        if (st.sdrive && wire_mode_select) begin
            sda_oe = 1'b1;
            sda_out = st.sosh[7];
        end else begin
            sda_oe = st.idrive;
            sda_out = 1'b0;
        end
    end

    assign serial_out_oe = st.sdrive & ~wire_mode_select;
    assign serial_out_line = st.sosh[7];
    assign reg_rd_addr = st.ptr;
    assign reg_rd_strobe = st.rd_strobe;
    assign reg_wr_strobe = st.wr.strobe;
    assign reg_wr_addr = st.wr.addr;
    assign reg_wr_data = st.wr.data;

endmodule

`default_nettype wire

// file: rtl/dsrp_defs.svh
// Constants for the dual serial register port: addresses, field positions,
// reset values and frame sizes.
// Assumes inclusion by bare name from the package and the port module.
`ifndef DSRP_DEFS_SVH
`define DSRP_DEFS_SVH

`define DSRP_SLAVE_ADDR 7'h47
`define DSRP_DIR_READ 1'b1
`define DSRP_DIR_WRITE 1'b0
`define DSRP_BYTE_LAST 3'h7
`define DSRP_I2C_BITS 4'h8
`define DSRP_SUB_INC_BIT 7
`define DSRP_SPI_RW_BIT 7
`define DSRP_SPI_MS_BIT 6
`define DSRP_ADDR_W 7
`define DSRP_DATA_W 8
`define DSRP_WIRE_MODE_RESET 1'b0
`define DSRP_TWO_WIRE_DIS_RESET 1'b0

`endif

// file: rtl/dsrp_pkg.sv
// Types shared by the dual serial register port.
// Assumes the constants header is on the include path.
`include "dsrp_defs.svh"

package dsrp_pkg;

    typedef enum logic [3:0] {
        DSRP_I_IDLE,
        DSRP_I_ADDR,
        DSRP_I_SUB,
        DSRP_I_WDATA,
        DSRP_I_ACK,
        DSRP_I_RDATA,
        DSRP_I_MACK
    } dsrp_i2c_state_t;

    typedef struct packed {
        logic [2:0] cs;
        logic [2:0] scl;
        logic [2:0] sda;
    } dsrp_sync_t;

    typedef struct packed {
        logic strobe;
        logic [`DSRP_ADDR_W-1:0] addr;
        logic [`DSRP_DATA_W-1:0] data;
    } dsrp_write_t;

    typedef struct packed {
        dsrp_sync_t sync;
        dsrp_i2c_state_t ist;
        dsrp_i2c_state_t iret;
        logic [3:0] icnt;
        logic [`DSRP_DATA_W-1:0] ish;
        logic irw;
        logic iinc;
        logic idrive;
        logic [2:0] sbit;
        logic sphase;
        logic srw;
        logic sms;
        logic [`DSRP_DATA_W-1:0] ssh;
        logic [`DSRP_DATA_W-1:0] sosh;
        logic sdrive;
        logic [`DSRP_ADDR_W-1:0] ptr;
        dsrp_write_t wr;
        logic rd_strobe;
    } dsrp_state_t;

endpackage

// file: verif/dsrp_port_properties.sv
// Concurrent checks on the pins and write strobes of the serial port.
// Assumes it is bound into dsrp_port and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "dsrp_defs.svh"
module dsrp_port_properties (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic chip_select_pin,
    input wire logic scl_spc_pin,
    input wire logic two_wire_disable,
    input wire logic wire_mode_select,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic serial_out_line,
    input wire logic serial_out_oe,
    input wire logic reg_rd_strobe,
    input wire logic reg_wr_strobe,
    input wire logic [`DSRP_ADDR_W-1:0] reg_wr_addr,
    input wire logic [`DSRP_DATA_W-1:0] reg_wr_data
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // Eight samples cover the three synchroniser stages plus the output flop.
    sequence s_idle;
        chip_select_pin [*8];
    endsequence
    sequence s_spi4;
        (!chip_select_pin && !wire_mode_select) [*8];
    endsequence
    sequence s_off;
        (chip_select_pin && two_wire_disable) [*8];
    endsequence
    a_wr_pulse: assert property (reg_wr_strobe |=> !reg_wr_strobe)
        else $error("write strobe too long");
    a_rd_pulse: assert property (reg_rd_strobe |=> !reg_rd_strobe)
        else $error("read strobe too long");
    a_wr_held: assert property (reg_wr_strobe |=>
        $stable(reg_wr_addr) && $stable(reg_wr_data)) else $error("write moved");
    a_idle_so_off: assert property (s_idle |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_spi_no_bus: assert property (s_spi4 |-> !sda_oe)
        else $error("data pin driven during spi");
    a_disable_quiet: assert property (s_off |-> !sda_oe)
        else $error("disabled slave drives");
    a_pull_low: assert property (s_idle ##0 sda_oe |-> !sda_out)
        else $error("bus driven high");
    a_one_driver: assert property (!(sda_oe && serial_out_oe))
        else $error("both outputs driven");
    a_so_on_fall: assert property (serial_out_oe && $past(serial_out_oe)
        && $changed(serial_out_line) |-> !scl_spc_pin) else $error("late shift");
endmodule
bind dsrp_port dsrp_port_properties u_props (.clk_sys, .reset,
    .chip_select_pin, .scl_spc_pin, .two_wire_disable, .wire_mode_select,
    .sda_out, .sda_oe, .serial_out_line, .serial_out_oe, .reg_rd_strobe,
    .reg_wr_strobe, .reg_wr_addr, .reg_wr_data);
`default_nettype wire

// file: verif/dsrp_host.sv
// Host master model: drives select, clock and data pins for both protocols.
// Assumes the bench resolves the shared data line and feeds it back.
`timescale 1ns/100ps
`default_nettype none
module dsrp_host (
    input wire logic clk_sys,
    input wire logic sda_line,
    input wire logic so_line,
    output logic spi_sel_n,
    output logic clk_pin,
    output logic data_pin
);
    initial begin
        spi_sel_n = 1'b1;
        clk_pin = 1'b1;
        data_pin = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Data moves mid low phase so it never forms a false start or stop.
    task automatic bit_x(input logic tx, input logic three, output logic rx);
        clk_pin = 1'b0;
        w(5);
        data_pin = tx;
        w(5);
        clk_pin = 1'b1;
        w(10);
        rx = three ? sda_line : so_line;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic three,
        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], three, rx[i]);
        end
    endtask
    task automatic spi(input logic [7:0] c, d0, d1, input logic three,
        output logic [7:0] r0, r1);
        logic [7:0] junk;
        spi_sel_n = 1'b0;
        w(10);
        xfer(c, three, junk);
        xfer(d0, three, r0);
        xfer(d1, three, r1);
        w(10);
        spi_sel_n = 1'b1;
        data_pin = 1'b1;
        w(20);
    endtask
    task automatic edge_pair(input logic a, input logic b);
        clk_pin = 1'b0;
        w(5);
        data_pin = a;
        w(5);
        clk_pin = 1'b1;
        w(10);
        data_pin = b;
        w(10);
    endtask
    task automatic ibyte(input logic [7:0] tx, input logic ack_in,
        output logic [7:0] rx, output logic ack_out);
        xfer(tx, 1'b1, rx);
        bit_x(ack_in, 1'b1, ack_out);
    endtask
endmodule
`default_nettype wire

// file: verif/test_dsrp_port.sv
// Self-checking bench for the serial port, with a behavioural register file.
// Assumes dsrp_host plays the master and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
module test_dsrp_port;
    logic clk_sys, reset, wire_mode_select, two_wire_disable, busy;
    logic sda_out, sda_oe, serial_out_line, serial_out_oe, sel_n, scl, dpin;
    logic reg_rd_strobe, reg_wr_strobe;
    logic [6:0] reg_rd_addr, reg_wr_addr;
    logic [7:0] reg_rdata, reg_wr_data;
    logic [14:0] wq[$];
    int err_total = 0;
    int cmp_count = 0;
    wire logic sda_line = dpin & (!sda_oe | sda_out);
    wire logic so_line = serial_out_oe ? serial_out_line : ~serial_out_line;
    function automatic logic [7:0] rd_exp(input logic [6:0] a);
        return {1'b0, a} ^ 8'hc3;
    endfunction
    assign reg_rdata = rd_exp(reg_rd_addr);
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (reg_wr_strobe) wq.push_back({reg_wr_addr, reg_wr_data});
    end
    dsrp_host u_host (.clk_sys(clk_sys), .sda_line(sda_line),
        .so_line(so_line), .spi_sel_n(sel_n), .clk_pin(scl), .data_pin(dpin));
    dsrp_port u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
        .chip_select_pin(sel_n), .scl_spc_pin(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .serial_out_line(serial_out_line),
        .serial_out_oe(serial_out_oe), .wire_mode_select(wire_mode_select),
        .two_wire_disable(two_wire_disable), .busy(busy),
        .reg_rd_addr(reg_rd_addr), .reg_rd_strobe(reg_rd_strobe),
        .reg_rdata(reg_rdata), .reg_wr_strobe(reg_wr_strobe),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));
    task automatic chk(input logic [14:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_wr(input logic [14:0] exp);
        chk(wq.size() ? wq.pop_front() : 15'hx, exp);
    endtask
    task automatic t_spi_write;
        logic [7:0] r0, r1;
        u_host.spi(8'h61, 8'ha5, 8'h3c, 1'b0, r0, r1);
        chk_wr({7'h21, 8'ha5});
        chk_wr({7'h22, 8'h3c});
        u_host.spi(8'h10, 8'h11, 8'h22, 1'b0, r0, r1);
        chk_wr({7'h10, 8'h11});
        chk_wr({7'h10, 8'h22});
        $display("spi write done");
    endtask
    task automatic t_spi_read(input logic three, input logic ms);
        logic [7:0] r0, r1;
        wire_mode_select = three;
        u_host.spi({1'b1, ms, 6'h2a}, 8'hff, 8'hff, three, r0, r1);
        chk({7'h0, r0}, {7'h0, rd_exp(7'h2a)});
        chk({7'h0, r1}, {7'h0, rd_exp(7'h2a + {6'h0, ms})});
        $display("spi read mode %0d step %0d done", three, ms);
    endtask
    task automatic t_i2c_write;
        logic [7:0] r;
        logic [3:0] a;
        u_host.edge_pair(1'b1, 1'b0);
        u_host.ibyte(8'h8e, 1'b1, r, a[3]);
        u_host.ibyte(8'h85, 1'b1, r, a[2]);
        u_host.ibyte(8'h5a, 1'b1, r, a[1]);
        u_host.ibyte(8'h66, 1'b1, r, a[0]);
        u_host.edge_pair(1'b0, 1'b1);
        chk({11'h0, a}, 15'h0);
        chk_wr({7'h05, 8'h5a});
        chk_wr({7'h06, 8'h66});
        $display("two-wire write done");
    endtask
    task automatic t_i2c_read;
        logic [7:0] r, d0, d1;
        logic [2:0] a;
        logic na;
        u_host.edge_pair(1'b1, 1'b0);
        u_host.ibyte(8'h8e, 1'b1, r, a[2]);
        u_host.ibyte(8'h83, 1'b1, r, a[1]);
        u_host.edge_pair(1'b1, 1'b0);
        u_host.ibyte(8'h8f, 1'b1, r, a[0]);
        u_host.ibyte(8'hff, 1'b0, d0, na);
        u_host.ibyte(8'hff, 1'b1, d1, na);
        u_host.edge_pair(1'b0, 1'b1);
        chk({12'h0, a}, 15'h0);
        chk({7'h0, d0}, {7'h0, rd_exp(7'h03)});
        chk({7'h0, d1}, {7'h0, rd_exp(7'h04)});
        $display("two-wire read done");
    endtask
    // Wrong address, then busy, then disabled: none may be acknowledged.
    task automatic t_i2c_refuse;
        logic [7:0] r;
        logic a;
        for (int i = 0; i < 3; i++) begin
            busy = (i == 1);
            two_wire_disable = (i == 2);
            u_host.edge_pair(1'b1, 1'b0);
            u_host.ibyte((i == 0) ? 8'h8c : 8'h8e, 1'b1, r, a);
            u_host.edge_pair(1'b0, 1'b1);
            chk({14'h0, a}, 15'h1);
        end
        busy = 1'b0;
        two_wire_disable = 1'b0;
        $display("two-wire refusal done");
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        wire_mode_select = 1'b0;
        two_wire_disable = 1'b0;
        busy = 1'b0;
        u_host.w(3);
        reset = 1'b0;
        u_host.w(6);
        chk({11'h0, sda_oe, serial_out_oe, reg_wr_strobe, reg_rd_strobe},
            15'h0);
        t_spi_write();
        for (int i = 0; i < 4; i++) begin
            t_spi_read(i[1], i[0]);
        end
        wire_mode_select = 1'b0;
        t_i2c_write();
        t_i2c_read();
        t_i2c_refuse();
        conclude();
    end
endmodule
`default_nettype wire
